// *** verilog/rx_start_sampler.sv ***
// Purpose: start-bit search, bit voting, resync, framing and break detect
// Assumes: rxd is synchronous to sys_clk; APB slave with zero wait states
// Notes:   status bits are sticky and clear on a status read; set wins
//
// Our own choices: register access over APB and the register addresses.
`include "rx_sampler_params.svh"

// Operation
// RQ1: sample line sixteen times per bit, phases 1-16
// RQ2: start qualifies on three highs then low
// RQ3: vote phases 8,9,10; flag disagreement as noise
// RQ4: completion loads holding register, sets full, noise
// RQ5: two high verify samples discard tentative start
// RQ6: one high verify sample accepts, sets noise
// RQ7: phase wraps 16 to 1, keeps misalignment
// RQ8: start bit value always taken as zero
// RQ9: line samples shift continuously into history register
// RQ10: falling edge in frame resynchronises the phase
// RQ11: edge still valid with one high verify
// RQ12: framing error forces highs at phases 14-16
// RQ13: framing error with all-zero data is break
// RQ14: no forced highs when a break is seen
// RQ15: eight or nine data bits per frame
// RQ16: stop bit decided by majority vote
// RQ17: framing error reported with completed character
// RQ18: sender rate keeps two stop samples inside
module rx_start_sampler
  import rx_sampler_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic [8:0]       receiveHoldingData,
  output logic             charDone,
  output logic             irq
);

  // bit rate default derived from the clock, for reference by software
  localparam int DIV_NOMINAL = `RX_SYS_HZ / (`RX_OVERSAMPLE * `RX_BAUD_DEFAULT);

  // two of three vote, used for verify samples and data samples
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // any disagreement among three samples
  function automatic logic split3(input logic a, input logic b, input logic c);
    split3 = (a != b) || (b != c);
  endfunction

  logic             rstMeta_r;     // reset release, first stage
  logic             resetN;        // reset release, second stage
  logic [1:0]       ctrl_r;        // enable and nine-bit select
  logic [15:0]      div_r;         // tick divisor
  logic [3:0]       mask_r;        // interrupt mask
  logic [3:0]       status_r;      // sticky flags
  logic [9:0]       hist_r;        // oversampled line history
  logic [9:0]       histNow;       // history including this tick's sample
  logic             sampleIn;      // sample shifted this tick
  rx_state_e        state_r;       // receiver state
  phase_t           phase_r;       // phase expected at the next tick
  phase_t           phaseCur;      // phase of the current tick
  phase_t           phaseNxt;      // phase after this tick
  bitcnt_t          bitCnt_r;      // 0 start, 1..N data, N+1 stop
  bitcnt_t          stopIdx;       // index of the stop bit
  logic [8:0]       shift_r;       // data shifter, lsb first
  logic             v3_r;          // verify sample at phase 3
  logic             v5_r;          // verify sample at phase 5
  logic             d8_r;          // data sample at phase 8
  logic             d9_r;          // data sample at phase 9
  logic             noiseW_r;      // working noise for this character
  logic             inject_r;      // force highs into the tail
  logic             tick;          // sixteen-times bit-rate strobe
  logic             qualify;       // start qualifier seen this tick
  logic             resync;        // mid-frame falling edge seen
  logic             stopNow;       // stop decided this tick
  logic             bitVal;        // voted bit value
  logic             bitNoise;      // voted samples disagree
  logic [8:0]       charData;      // aligned character
  logic             frameErr;      // stop voted low
  logic             breakSeen;     // framing error with zero data
  logic             busRead;       // access phase of a read
  logic             busWrite;      // access phase of a write
  logic             statusRead;    // read of the status register
  logic [3:0]       evtSet;        // flags raised this cycle

  // reset is released through two flops so every flop leaves reset together
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_r <= 1'b0;
      resetN    <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      resetN    <= rstMeta_r;
    end
  end

  // oversample strobe; a divider keeps the whole block on sys_clk
  sample_tick_gen tickGen (
    .sys_clk (sys_clk),
    .resetN  (resetN),
    .enable  (ctrl_r[`RX_CTRL_EN]),
    .divisor (div_r),
    .tick    (tick)
  );  // [RQ1]

  // tail highs replace the line after a plain framing error; forcing the
  // sample rather than the pin keeps the effect to the three tail phases
  // and leaves the holding data and flags of that character untouched
  always_comb begin
    sampleIn = rxd;
    if (state_r == ST_TAIL && inject_r && phase_r >= `RX_PH_INJ) begin
      sampleIn = 1'b1;  // [RQ12] [RQ14]
    end
  end

  // newest sample sits in bit 0
  assign histNow = {hist_r[8:0], sampleIn};

  // sample history, shifted on every tick
  always_ff @(posedge sys_clk or negedge resetN) begin
    if (!resetN) begin
      hist_r <= 10'h000;
    end else if (!ctrl_r[`RX_CTRL_EN]) begin
      hist_r <= 10'h000;  // enable needs three fresh highs before a start
    end else if (tick) begin
      hist_r <= histNow;  // [RQ9]
    end
  end

  // three highs then a low at this tick
  assign qualify = (histNow[3:1] == 3'b111) && !histNow[0];  // [RQ2]

  // edge six ticks back with lows at phases 1,3,5,7; one high tolerated
  // limitation: not armed in the start bit, where the verify samples
  // already settle alignment; a drift of more than a few phases per
  // frame cannot be recovered because the bit count has moved on
  assign resync = (state_r == ST_FRAME) && (bitCnt_r != 4'h0) &&
                  (histNow[9:7] == 3'b111) && !histNow[6] &&
                  !maj3(histNow[4], histNow[2], histNow[0]);  // [RQ10] [RQ11]

  // a resync treats this tick as phase 7 of the new bit
  // trade-off: snapping may repeat or skip a few phases, but the votes
  // at 8, 9 and 10 always land mid-bit, seven to nine ticks after the realigned edge
  assign phaseCur = resync ? `RX_PH_V3 : phase_r;

  // wrap back to 1 at the perceived boundary
  assign phaseNxt = (phaseCur == `RX_PH_LAST) ? `RX_PH_FIRST : phaseCur + 5'h01;  // [RQ7]

  // frame length follows the nine-bit select
  assign stopIdx = ctrl_r[`RX_CTRL_NINE] ? 4'ha : 4'h9;  // [RQ15]

  // majority of the three data samples decides each data bit and the stop bit
  assign bitVal   = maj3(d8_r, d9_r, sampleIn);  // [RQ3] [RQ16]
  assign bitNoise = split3(d8_r, d9_r, sampleIn);  // [RQ3]

  // stop bit decision moment
  // every flag and the data word are taken at this one tick, so they
  // always describe the same character
  assign stopNow = tick && (state_r == ST_FRAME) && (phaseCur == `RX_PH_D3) &&
                   (bitCnt_r == stopIdx);

  // eight-bit data is left in the upper bits of the shifter
  assign charData  = ctrl_r[`RX_CTRL_NINE] ? shift_r : {1'b0, shift_r[8:1]};
  assign frameErr  = !bitVal;  // [RQ17]
  assign breakSeen = frameErr && (charData == 9'h000);  // [RQ13]

  // receiver sequencing: search, verify, sample and frame
  always_ff @(posedge sys_clk or negedge resetN) begin
    if (!resetN) begin
      state_r  <= ST_SEARCH;
      phase_r  <= `RX_PH_FIRST;
      bitCnt_r <= 4'h0;
      shift_r  <= 9'h000;
      v3_r     <= 1'b0;
      v5_r     <= 1'b0;
      d8_r     <= 1'b0;
      d9_r     <= 1'b0;
      noiseW_r <= 1'b0;
      inject_r <= 1'b0;
    end else if (!ctrl_r[`RX_CTRL_EN]) begin
      state_r  <= ST_SEARCH;  // disabled: drop any partial character
      phase_r  <= `RX_PH_FIRST;
      inject_r <= 1'b0;
    end else if (tick) begin
      case (state_r)
        ST_SEARCH, ST_TAIL: begin
          if (qualify) begin
            state_r  <= ST_FRAME;  // tentative start, this tick is phase 1
            phase_r  <= `RX_PH_FIRST + 5'h01;  // [RQ2]
            bitCnt_r <= 4'h0;
            noiseW_r <= 1'b0;
            inject_r <= 1'b0;
          end else if (state_r == ST_TAIL && phase_r != `RX_PH_LAST) begin
            phase_r <= phase_r + 5'h01;  // finish the perceived stop bit
          end else begin
            state_r  <= ST_SEARCH;
            phase_r  <= `RX_PH_FIRST;  // held at 1 while searching [RQ2]
            inject_r <= 1'b0;
          end
        end
        ST_FRAME: begin
          phase_r <= phaseNxt;  // [RQ1] [RQ7]
          if (phaseCur == `RX_PH_LAST) begin
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          case (phaseCur)
            `RX_PH_V1: begin
              v3_r <= sampleIn;
            end
            `RX_PH_V2: begin
              v5_r <= sampleIn;
            end
            `RX_PH_V3: begin
              if (bitCnt_r == 4'h0 && !resync) begin
                if (maj3(v3_r, v5_r, sampleIn)) begin
                  state_r <= ST_SEARCH;  // low at phase 1 was noise [RQ5]
                  phase_r <= `RX_PH_FIRST;
                end else if (v3_r || v5_r || sampleIn) begin
                  noiseW_r <= 1'b1;  // [RQ6]
                end
              end
            end
            `RX_PH_D1: begin
              d8_r <= sampleIn;  // [RQ3]
            end
            `RX_PH_D2: begin
              d9_r <= sampleIn;  // [RQ3]
            end
            `RX_PH_D3: begin
              if (bitNoise) begin
                noiseW_r <= 1'b1;  // start and stop included [RQ3]
              end
              if (bitCnt_r == stopIdx) begin
                state_r  <= ST_TAIL;  // [RQ16]
                inject_r <= frameErr && !breakSeen;  // [RQ12] [RQ14]
              end else if (bitCnt_r != 4'h0) begin
                shift_r <= {bitVal, shift_r[8:1]};  // start bit is never shifted [RQ8]
              end
            end
            default: begin
            end
          endcase
        end
        default: begin
          state_r <= ST_SEARCH;
          phase_r <= `RX_PH_FIRST;
        end
      endcase
    end
  end

  // completed character goes to the holding register
  // each character overwrites the last; overrun is left to the buffer
  // stage behind this block, which sees charDone
  always_ff @(posedge sys_clk or negedge resetN) begin
    if (!resetN) begin
      receiveHoldingData <= 9'h000;
      charDone           <= 1'b0;
    end else begin
      charDone <= stopNow;
      if (stopNow) begin
        receiveHoldingData <= charData;  // [RQ4]
      end
    end
  end

  // APB decode; zero wait states, so each access ends in its first access cycle
  // a status read in the access phase is the only side effect of a read
  assign busRead    = psel && penable && !pwrite;
  assign busWrite   = psel && penable && pwrite;
  assign statusRead = busRead && (paddr == `RX_OFF_STATUS);
  assign pready     = 1'b1;

  // unmapped addresses answer with an error and read as zero
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      `RX_OFF_CTRL:   prdata = {30'h0000_0000, ctrl_r};
      `RX_OFF_DIV:    prdata = {16'h0000, div_r};
      `RX_OFF_STATUS: prdata = {28'h000_0000, status_r};
      `RX_OFF_MASK:   prdata = {28'h000_0000, mask_r};
      `RX_OFF_DATA:   prdata = {23'h00_0000, receiveHoldingData};
      default:        pslverr = psel && penable;
    endcase
  end

  // software-written control
  // writes to unmapped offsets fall into the default and change nothing
  always_ff @(posedge sys_clk or negedge resetN) begin
    if (!resetN) begin
      ctrl_r <= `RX_CTRL_RESET;
      div_r  <= `RX_DIV_RESET;
      mask_r <= `RX_MASK_RESET;
    end else if (busWrite) begin
      case (paddr)
        `RX_OFF_CTRL: ctrl_r <= pwdata[1:0];
        `RX_OFF_DIV:  div_r  <= pwdata[15:0];
        `RX_OFF_MASK: mask_r <= pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // events of this cycle; noise and framing come with full
  assign evtSet[`RX_ST_FULL]  = stopNow;  // [RQ4]
  assign evtSet[`RX_ST_NOISE] = stopNow && (noiseW_r || bitNoise);  // [RQ4]
  assign evtSet[`RX_ST_FRAME] = stopNow && frameErr;  // [RQ17]
  assign evtSet[`RX_ST_BREAK] = stopNow && breakSeen;  // [RQ13]

  // sticky flags; a read clears them but a same-cycle event survives
  // hazard: letting the clear win would drop the flags of a character
  // that completes exactly as software polls
  always_ff @(posedge sys_clk or negedge resetN) begin
    if (!resetN) begin
      status_r <= 4'h0;
    end else begin
      status_r <= (statusRead ? 4'h0 : status_r) | evtSet;
    end
  end

  // level interrupt while any unmasked flag stands
  // computed from the next flag value so irq rises with charDone and
  // falls on the clearing read instead of one cycle late
  always_ff @(posedge sys_clk or negedge resetN) begin
    if (!resetN) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((statusRead ? 4'h0 : status_r) | evtSet) & mask_r);
    end
  end

endmodule

// *** verilog/rx_sampler_params.svh ***
// Purpose: constants for the oversampling receive front end
// Assumes: 20 MHz sys_clk, APB with 32-bit data
// Notes:   byte offsets, field positions, reset values, phase numbers
`ifndef RX_SAMPLER_PARAMS_SVH
`define RX_SAMPLER_PARAMS_SVH

// register byte offsets
`define RX_OFF_CTRL      8'h00
`define RX_OFF_DIV       8'h04
`define RX_OFF_STATUS    8'h08
`define RX_OFF_MASK      8'h0c
`define RX_OFF_DATA      8'h10

// control fields
`define RX_CTRL_EN       0
`define RX_CTRL_NINE     1

// status / mask fields
`define RX_ST_FULL       0
`define RX_ST_NOISE      1
`define RX_ST_FRAME      2
`define RX_ST_BREAK      3
`define RX_ST_W          4

// reset values
`define RX_CTRL_RESET    2'h0
`define RX_DIV_RESET     16'h0081
`define RX_MASK_RESET    4'h0

// timing: system clock and default bit rate
`define RX_SYS_HZ        20000000
`define RX_OVERSAMPLE    16
`define RX_BAUD_DEFAULT  9600

// oversample phase numbers within a bit
`define RX_PH_FIRST      5'h01
`define RX_PH_V1         5'h03
`define RX_PH_V2         5'h05
`define RX_PH_V3         5'h07
`define RX_PH_D1         5'h08
`define RX_PH_D2         5'h09
`define RX_PH_D3         5'h0a
`define RX_PH_INJ        5'h0e
`define RX_PH_LAST       5'h10

`endif

// *** verilog/rx_sampler_pkg.sv ***
// Purpose: types shared by the receive front end
// Assumes: nothing beyond the params header
// Notes:   phases are kept as 1..16 so comparisons read like the timing
package rx_sampler_pkg;
  typedef enum logic [1:0] {
    ST_SEARCH = 2'b00,  // hunting for a start edge
    ST_FRAME  = 2'b01,  // inside a character
    ST_TAIL   = 2'b10   // after the stop decision, up to phase 16
  } rx_state_e;
  typedef logic [4:0] phase_t;
  typedef logic [3:0] bitcnt_t;
endpackage

// *** verilog/rt_tick_gen.sv ***
// Purpose: divides sys_clk down to the sixteen-times bit-rate tick
// Assumes: synchronous reset copy from the top
// Notes:   one tick every divisor+1 clocks; held off while disabled
module sample_tick_gen (
  input  wire logic        sys_clk,
  input  wire logic        resetN,
  input  wire logic        enable,
  input  wire logic [15:0] divisor,
  output logic             tick
);
  logic [15:0] count_r;  // cycles left until the next tick

  // free-running down counter, restarted whenever the receiver is off
  always_ff @(posedge sys_clk or negedge resetN) begin
    if (!resetN) begin
      count_r <= 16'h0000;
    end else if (!enable || count_r == 16'h0000) begin
      count_r <= divisor;
    end else begin
      count_r <= count_r - 16'h0001;
    end
  end

  // tick is a one-cycle pulse; gated so a disabled receiver sees none
  assign tick = enable && (count_r == 16'h0000);
endmodule

// *** sim/serial_sender_model.sv ***
// Purpose: remote asynchronous sender driving the receive line
// Assumes: one bit lasts bitClks sys_clk cycles; a phase is a sixteenth of it
// Notes:   line idles high; optional noise before or inside the start bit
module serial_sender_model (
  input  wire logic sys_clk,
  output logic      rxd,
  output logic      busy
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rxd  = 1'b1;  // idle line is high
    busy = 1'b0;
  end

  // hold one level for n clocks, changing just after an edge
  task automatic hold(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge sys_clk);
  endtask

  // one frame, lsb first; gap>0 puts a one-phase low glitch and gap high phases first
  // chain leaves the line at the stop level so the next frame follows with no idle
  task automatic send(input logic [8:0] d, input logic nine, input logic stopV, input int gap,
                      input int bitClks, input logic spike, input logic chain);
    int ph;
    ph = bitClks / 16;
    busy <= 1'b1;
    if (gap > 0) begin
      hold(1'b0, ph);
      hold(1'b1, gap * ph);
    end
    if (spike) begin  // highs over the middle samples of the start bit
      hold(1'b0, 7 * ph);
      hold(1'b1, 2 * ph);
      hold(1'b0, 7 * ph);
    end else begin
      hold(1'b0, bitClks);
    end
    for (int i = 0; i < (nine ? 9 : 8); i++) hold(d[i], bitClks);  // bit rate set by caller
    hold(stopV, bitClks);
    if (!chain) begin
      rxd  <= 1'b1;  // released line returns to idle high
      busy <= 1'b0;
    end
  endtask
endmodule

// *** sim/rx_sampler_asserts.sv ***
// Purpose: port-level checks of the receive front end
// Assumes: single sys_clk domain, rstn as the disable
// Notes:   internal phase state is unseen; checks tie outputs to causes
module rx_sampler_asserts
  import rx_sampler_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd,
  input wire logic [8:0]  receiveHoldingData,
  input wire logic        charDone,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  wire logic   acc = psel && penable;  // APB access phase
  logic [15:0] gapCnt;                 // clocks since last character, saturating

  // a frame cannot finish sooner than 150 clocks after the last, at one clock per phase or more
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gapCnt <= 16'hffff;
    end else if (charDone) begin
      gapCnt <= 16'h0000;
    end else if (gapCnt != 16'hffff) begin
      gapCnt <= gapCnt + 16'h0001;
    end
  end

  property p_done_pulse; charDone |=> !charDone; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("charDone longer than one cycle");
  property p_data_cause; !$stable(receiveHoldingData) |-> charDone; endproperty
  a_data_cause: assert property (p_data_cause) else $error("holding data moved without a character");
  property p_frame_gap; charDone |-> gapCnt >= 16'd150; endproperty
  a_frame_gap: assert property (p_frame_gap) else $error("characters closer than a frame");
  property p_irq_cause;
    $rose(irq) |-> charDone || $past(charDone) || $past(acc && pwrite) || $past(acc && pwrite, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without a cause");
  property p_irq_drop;
    acc && !pwrite && paddr == 8'h08 && !charDone ##1 !charDone |-> ##[0:1] !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq stayed high after status read");
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_unmapped; acc && paddr > 8'h10 |-> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; acc && paddr[1:0] == 2'b00 && paddr <= 8'h10 |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_data_read; acc && !pwrite && paddr == 8'h10 |-> prdata == {23'h0, receiveHoldingData}; endproperty
  a_data_read: assert property (p_data_read) else $error("data read differs from holding data");

  c_done: cover property (charDone);
  c_err: cover property (acc && pslverr);
  c_irq: cover property ($rose(irq));
endmodule

bind rx_start_sampler rx_sampler_asserts chk_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd(rxd), .receiveHoldingData(receiveHoldingData), .charDone(charDone), .irq(irq));

// *** sim/test_uart_rx_start_bit_sampler.sv ***
// Purpose: self-checking bench for the oversampling receive front end
// Assumes: divisor 3, so a phase is 4 clocks and a bit 64 clocks
// Notes:   sender model drives rxd; registers reached over APB
`include "rx_sampler_params.svh"
module test_uart_rx_start_bit_sampler
  import rx_sampler_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;   // active low, held ten cycles
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rxd, charDone, irq, txBusy;
  logic [8:0]  holdData;
  int          nErrors = 0;
  int          nTests  = 0;
  int          cycles  = 0;

  rx_start_sampler dut_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .receiveHoldingData(holdData), .charDone(charDone), .irq(irq));
  serial_sender_model tx_u (.sys_clk(sys_clk), .rxd(rxd), .busy(txBusy));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // hang guard: the whole run needs about 8000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nErrors++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one APB transfer, request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  // read and compare; a refusal is expected only for addresses above the data word
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(what, rd, exp);
    check("pslverr", {31'h0, err}, {31'h0, a > 8'h10});
  endtask

  // bounded wait for a character, then data and interrupt
  task automatic waitDone(input logic [8:0] d);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (charDone !== 1'b1 && k < 2000);
    check("charDone", {31'h0, charDone}, 32'h1);
    check("holdData", {23'h0, holdData}, {23'h0, d});
    check("irq", {31'h0, irq}, 32'h1);
  endtask

  // sender done, then a bit time of idle highs so the next start can qualify
  task automatic idle;
    int k;
    k = 0;
    while (txBusy !== 1'b0 && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (64) @(posedge sys_clk);
    check("irq", {31'h0, irq}, 32'h0);
  endtask

  task automatic frame(input logic [8:0] d, input logic nine, input int gap, input int bitClks,
                       input logic spike, input logic [31:0] st);
    fork
      tx_u.send(d, nine, 1'b1, gap, bitClks, spike, 1'b0);
    join_none
    waitDone(d);
    rdchk("status", `RX_OFF_STATUS, st);
    idle();
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdchk("ctrl", `RX_OFF_CTRL, 32'h0);
    rdchk("div", `RX_OFF_DIV, 32'h81);
    rdchk("mask", `RX_OFF_MASK, 32'h0);
    rdchk("status", `RX_OFF_STATUS, 32'h0);
    rdchk("data", `RX_OFF_DATA, 32'h0);
    rdchk("unmapped", 8'h14, 32'h0);
    wr(`RX_OFF_DIV, 32'h3);
    wr(`RX_OFF_MASK, 32'hf);
    wr(`RX_OFF_CTRL, 32'h1);
    idle();
    frame(9'h0a5, 1'b0, 0, 64, 1'b0, 32'h1);
    frame(9'h03c, 1'b0, 2, 64, 1'b0, 32'h3);
    frame(9'h05a, 1'b0, 10, 64, 1'b0, 32'h1);
    frame(9'h066, 1'b0, 0, 64, 1'b1, 32'h3);
    frame(9'h0c3, 1'b0, 0, 66, 1'b0, 32'h1);
    frame(9'h0e1, 1'b0, 0, 62, 1'b0, 32'h1);
    // low stop bit with the next start straight after it
    fork
      begin
        tx_u.send(9'h081, 1'b0, 1'b0, 0, 64, 1'b0, 1'b1);
        tx_u.send(9'h042, 1'b0, 1'b1, 0, 64, 1'b0, 1'b0);
      end
    join_none
    waitDone(9'h081);
    rdchk("status", `RX_OFF_STATUS, 32'h5);
    waitDone(9'h042);
    rdchk("status", `RX_OFF_STATUS, 32'h1);
    idle();
    // all-zero character with low stop, then a start with no edge before data
    fork
      begin
        tx_u.send(9'h000, 1'b0, 1'b0, 0, 64, 1'b0, 1'b1);
        tx_u.send(9'h0ff, 1'b0, 1'b1, 0, 64, 1'b0, 1'b0);
      end
    join_none
    waitDone(9'h000);
    rdchk("status", `RX_OFF_STATUS, 32'hd);
    idle();
    rdchk("status", `RX_OFF_STATUS, 32'h0);
    rdchk("data", `RX_OFF_DATA, 32'h0);
    wr(`RX_OFF_CTRL, 32'h3);
    frame(9'h1a5, 1'b1, 0, 64, 1'b0, 32'h1);
    stop_test();
  end
endmodule
